// >>> rtl/grtc_pkg.sv
package grtc_pkg;
  localparam int        REG_ADDR_W       = 8;
  localparam int        REG_DATA_W       = 8;
  localparam logic [7:0] GLOBAL_CONTROL_OFS = 8'h00;
  localparam logic [7:0] GLOBAL_CONTROL_RST = 8'h00;
  localparam int        RUN_BIT          = 7;
  localparam int        AUTO_BIT         = 6;
  localparam int        ACT_HI           = 5;
  localparam int        ACT_LO           = 3;
  localparam int        SYNC_DIS_BIT     = 2;
  localparam int        STD_HI           = 1;
  localparam int        STD_LO           = 0;

  typedef enum logic [2:0] {
    ACT_RESET_ALL  = 3'h0,
    ACT_FLYWHEEL   = 3'h1,
    ACT_HOLD_LOCK  = 3'h2,
    ACT_RESET_LOOP = 3'h3,
    ACT_RESET_SM   = 3'h4,
    ACT_BLUE_LOCK  = 3'h5,
    ACT_GRAB       = 3'h6,
    ACT_TOGGLE     = 3'h7
  } grtc_action_type;

  typedef enum logic [1:0] {
    STD_NTSC  = 2'h0,
    STD_RSVD  = 2'h1,
    STD_PAL_M = 2'h2,
    STD_PAL   = 2'h3
  } grtc_std_type;

  // Control lines fed to the decoder core
  typedef struct packed {
    logic sm_reset;
    logic loop_reset;
    logic outputs_hiz;
    logic force_blue;
    logic force_color;
    logic lock_external;
    logic grab_strobe;
  } grtc_ctrl_type;

  typedef struct packed {
    logic hsync;
    logic vsync;
  } grtc_sync_type;
endpackage

// >>> rtl/grtc_global_control.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
// Overview of operation
// - Run bit low resets state machines, disables outputs
// - Run bit high runs machines, drives outputs
// - Auto restart set ignores run bit writes
// - Auto restart, reset pin low clears run
// - Auto restart clear, wait host run write
// - Auto restart re-enables when pin high
// - Bits 5-3 choose trigger pin action
// - Code 000 resets outputs, machines, loop
// - Code 001 forces blue/colour, flywheel
// - Code 010 hi-z outputs, lock external
// - 011 resets loop; 100 resets both
// - Code 101 blue output, lock external
// - Code 110 performs line/pixel grab
// - Code 111 each pulse toggles 010 mode
// - After reset first toggle enters 010
// - Sync disable bit suppresses decoded syncs
// - Bits 1-0 select video standard
module grtc_global_control
  import grtc_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic [REG_ADDR_W-1:0]      reg_addr_in,
  input  wire logic [REG_DATA_W-1:0]      reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic      [REG_DATA_W-1:0]      reg_rdata_out,
  input  wire logic                       reset_pin_n_in,
  input  wire logic                       trigger_pin_n_in,
  input  wire grtc_pkg::grtc_sync_type    sync_in,
  output grtc_pkg::grtc_sync_type         sync_out,
  output grtc_pkg::grtc_ctrl_type         ctrl_out,
  output grtc_pkg::grtc_std_type          video_standard_select_out
);
  import grtc_pkg::*;

  logic [1:0]          rst_sync_q;
  logic [1:0]          trg_sync_q;
  logic                trg_prev_q;
  logic                soft_run_enable_q;
  logic                pin_reset_auto_restart_q;
  grtc_action_type     action_q;
  logic                sync_output_disable_q;
  grtc_std_type        std_q;
  logic                toggle_q;
  logic                trg_fall;
  logic                trg_low;
  logic                pin_low;
  logic                wr_ctl;
  grtc_ctrl_type       ctrl_d;

  // Read-back word and field casts depend on this packing
  if (RUN_BIT != REG_DATA_W - 1 || AUTO_BIT != RUN_BIT - 1 ||
      ACT_HI != AUTO_BIT - 1 || SYNC_DIS_BIT != ACT_LO - 1) begin : g_upper_chk
    $error("control word upper fields are not packed as expected");
  end
  if (ACT_HI - ACT_LO + 1 != $bits(grtc_action_type) || STD_HI != SYNC_DIS_BIT - 1 ||
      STD_HI - STD_LO + 1 != $bits(grtc_std_type) || STD_LO != 0) begin : g_lower_chk
    $error("control word lower fields are not packed as expected");
  end

  // Second stage only is read; first stage feeds nothing else
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rst_sync_q <= 2'h0;
      trg_sync_q <= 2'h3;
      trg_prev_q <= 1'b1;
    end else begin
      rst_sync_q <= {rst_sync_q[0], reset_pin_n_in};
      trg_sync_q <= {trg_sync_q[0], trigger_pin_n_in};
      trg_prev_q <= trg_sync_q[1];
    end
  end

  assign pin_low  = ~rst_sync_q[1];
  assign trg_low  = ~trg_sync_q[1];
  assign trg_fall = trg_prev_q & ~trg_sync_q[1];
  assign wr_ctl   = reg_wr_in && (reg_addr_in == GLOBAL_CONTROL_OFS);

  // Run bit: pin control wins over host while auto restart is set
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      soft_run_enable_q <= GLOBAL_CONTROL_RST[RUN_BIT];
    end else if (pin_reset_auto_restart_q) begin
      soft_run_enable_q <= ~pin_low;
    end else if (wr_ctl) begin
      soft_run_enable_q <= reg_wdata_in[RUN_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_reset_auto_restart_q <= GLOBAL_CONTROL_RST[AUTO_BIT];
      action_q                 <= ACT_RESET_ALL;
      sync_output_disable_q    <= GLOBAL_CONTROL_RST[SYNC_DIS_BIT];
      std_q                    <= STD_NTSC;
    end else if (wr_ctl) begin
      pin_reset_auto_restart_q <= reg_wdata_in[AUTO_BIT];
      action_q                 <= grtc_action_type'(reg_wdata_in[ACT_HI:ACT_LO]);
      sync_output_disable_q    <= reg_wdata_in[SYNC_DIS_BIT];
      std_q                    <= grtc_std_type'(reg_wdata_in[STD_HI:STD_LO]);
    end
  end

  // Toggle state cleared by any reset so first pulse enters hold mode
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      toggle_q <= 1'b0;
    end else if (!soft_run_enable_q) begin
      toggle_q <= 1'b0;
    end else if (action_q == ACT_TOGGLE && trg_fall) begin
      toggle_q <= ~toggle_q;
    end
  end

  always_comb begin
    ctrl_d = '0;
    if (!soft_run_enable_q) begin
      ctrl_d.sm_reset    = 1'b1;
      ctrl_d.outputs_hiz = 1'b1;
    end else begin
      case (action_q)
        ACT_RESET_ALL: begin
          ctrl_d.outputs_hiz = trg_low;
          ctrl_d.sm_reset    = trg_low;
          ctrl_d.loop_reset  = trg_low;
        end
        ACT_FLYWHEEL: begin
          ctrl_d.force_blue  = trg_low;
          ctrl_d.force_color = trg_low;
        end
        ACT_HOLD_LOCK: begin
          ctrl_d.outputs_hiz   = trg_low;
          ctrl_d.lock_external = trg_low;
        end
        ACT_RESET_LOOP: begin
          ctrl_d.loop_reset = trg_low;
        end
        ACT_RESET_SM: begin
          ctrl_d.sm_reset   = trg_low;
          ctrl_d.loop_reset = trg_low;
        end
        ACT_BLUE_LOCK: begin
          ctrl_d.force_blue    = trg_low;
          ctrl_d.lock_external = trg_low;
        end
        ACT_GRAB: begin
          ctrl_d.grab_strobe = trg_fall;
        end
        ACT_TOGGLE: begin
          ctrl_d.outputs_hiz   = toggle_q;
          ctrl_d.lock_external = toggle_q;
        end
        default: ctrl_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_out <= '{sm_reset: 1'b1, outputs_hiz: 1'b1, default: 1'b0};
    end else begin
      ctrl_out <= ctrl_d;
    end
  end

  // Syncs suppressed while disabled or while the run bit is low
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync_out <= '0;
    end else if (sync_output_disable_q || !soft_run_enable_q) begin
      sync_out <= '0;
    end else begin
      sync_out <= sync_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      video_standard_select_out <= STD_NTSC;
    end else begin
      video_standard_select_out <= std_q;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in && reg_addr_in == GLOBAL_CONTROL_OFS) begin
      reg_rdata_out <= {soft_run_enable_q, pin_reset_auto_restart_q, action_q,
                        sync_output_disable_q, std_q};
    end else begin
      reg_rdata_out <= '0;
    end
  end

  property run_low_holds_p;
    @(posedge clk_in) disable iff (sys_rst_in)
      !soft_run_enable_q |=> ctrl_out.sm_reset && ctrl_out.outputs_hiz;
  endproperty
  run_low_hold_a: assert property (run_low_holds_p) else $error("run low not held");

  sequence pin_held_low_s;
    pin_reset_auto_restart_q && pin_low;
  endsequence
  auto_pin_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pin_held_low_s |=> !soft_run_enable_q) else $error("pin low did not clear run");

  auto_restart_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pin_reset_auto_restart_q && !pin_low |=> soft_run_enable_q)
    else $error("no auto restart");

  write_ignored_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pin_reset_auto_restart_q && pin_low && wr_ctl && reg_wdata_in[RUN_BIT]
    |=> !soft_run_enable_q) else $error("run write not ignored");

  manual_wait_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !pin_reset_auto_restart_q && !soft_run_enable_q && !wr_ctl |=> !soft_run_enable_q)
    else $error("run set without host write");

  reset_all_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    soft_run_enable_q && action_q == ACT_RESET_ALL && trg_low
    |=> ctrl_out.sm_reset && ctrl_out.loop_reset && ctrl_out.outputs_hiz)
    else $error("code 000 not applied");

  loop_only_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    soft_run_enable_q && action_q == ACT_RESET_LOOP && trg_low
    |=> ctrl_out.loop_reset && !ctrl_out.sm_reset) else $error("code 011 wrong");

  toggle_step_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    soft_run_enable_q && action_q == ACT_TOGGLE && trg_fall
    |=> toggle_q != $past(toggle_q)) else $error("toggle missed");

  sync_block_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    sync_output_disable_q |=> sync_out == '0) else $error("sync not suppressed");

  // Checked against the pin itself, two edges back, so a bad stage order shows
  edge_detect_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    trg_fall |-> !$past(trigger_pin_n_in, 2) && !$past(trg_fall)) else $error("bad edge");

  // Run high with trigger idle and toggle state clear must leave the core free
  run_high_drive_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    soft_run_enable_q && !trg_low && !toggle_q
    |=> !ctrl_out.sm_reset && !ctrl_out.outputs_hiz)
    else $error("run high but core held");

  // Syncs pass one register late while enabled
  sync_pass_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    soft_run_enable_q && !sync_output_disable_q |=> sync_out == $past(sync_in))
    else $error("sync not passed through");

  action_load_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctl |=> action_q == $past(reg_wdata_in[ACT_HI:ACT_LO]))
    else $error("action code not loaded");

  // Level actions: each code drives its own lines and leaves the rest alone
  flywheel_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    soft_run_enable_q && action_q == ACT_FLYWHEEL && trg_low
    |=> ctrl_out.force_blue && ctrl_out.force_color && !ctrl_out.sm_reset
        && !ctrl_out.loop_reset) else $error("code 001 wrong");

  hold_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    soft_run_enable_q && action_q == ACT_HOLD_LOCK && trg_low
    |=> ctrl_out.outputs_hiz && ctrl_out.lock_external && !ctrl_out.sm_reset)
    else $error("code 010 wrong");

  reset_both_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    soft_run_enable_q && action_q == ACT_RESET_SM && trg_low
    |=> ctrl_out.sm_reset && ctrl_out.loop_reset && !ctrl_out.outputs_hiz)
    else $error("code 100 wrong");

  blue_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    soft_run_enable_q && action_q == ACT_BLUE_LOCK && trg_low
    |=> ctrl_out.force_blue && ctrl_out.lock_external && !ctrl_out.outputs_hiz)
    else $error("code 101 wrong");

  // Grab is one strobe per trigger edge, never a level
  sequence grab_edge_s;
    soft_run_enable_q && action_q == ACT_GRAB && trg_fall;
  endsequence
  sequence grab_pulse_s;
    ctrl_out.grab_strobe ##1 !ctrl_out.grab_strobe;
  endsequence
  grab_pulse_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    grab_edge_s |=> grab_pulse_s) else $error("grab strobe not one cycle");
  grab_quiet_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !trg_fall |=> !ctrl_out.grab_strobe) else $error("grab strobe without edge");

  // First pulse after any reset lands in hold mode; run must survive the step
  sequence toggle_arm_s;
    soft_run_enable_q && action_q == ACT_TOGGLE && !toggle_q && trg_fall
    && !wr_ctl && !(pin_reset_auto_restart_q && pin_low);
  endsequence
  sequence hold_entered_s;
    ctrl_out.outputs_hiz && ctrl_out.lock_external && !ctrl_out.sm_reset;
  endsequence
  toggle_first_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    toggle_arm_s |=> ##1 hold_entered_s) else $error("first toggle missed hold");
  toggle_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !soft_run_enable_q |=> !toggle_q) else $error("toggle state survived reset");

  std_follow_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ctl |=> ##1 video_standard_select_out == $past(reg_wdata_in[STD_HI:STD_LO], 2))
    else $error("standard not applied");
endmodule

// >>> dv/grtc_pin_model.sv
`timescale 1ns/1ns
// External pin logic; pins idle high, commands land one edge later
module grtc_pin_model (
  input  wire logic clk_in,
  input  wire logic rst_req_in,
  input  wire logic trig_req_in,
  output logic      reset_pin_n_out,
  output logic      trigger_pin_n_out
);
  always @(posedge clk_in) begin
    reset_pin_n_out <= ~rst_req_in;
    trigger_pin_n_out <= ~trig_req_in;
  end
endmodule

// >>> dv/tb_global_reset_trigger_control.sv
`timescale 1ns/1ns
module tb_global_reset_trigger_control;
  import grtc_pkg::*;
  logic          clk_in = 1'b0;
  logic          sys_rst_in = 1'b1;
  logic [7:0]    addr = 8'h00, wdata = 8'h00, rdata, d;
  logic          wr = 1'b0, rd = 1'b0, rst_req = 1'b0, trig_req = 1'b0, rst_n, trig_n;
  grtc_sync_type sync_in = 2'h0, sync_out;
  grtc_ctrl_type ctrl;
  grtc_std_type  std;
  int            num_errors = 0, total_checks = 0, cycles = 0, grabs;
  // Rows: action code, then expected ctrl while trigger is low
  localparam logic [9:0] ROWS [6] = '{10'h070, 10'h08c, 10'h112, 10'h1a0, 10'h260, 10'h28a};
  initial forever #4 clk_in = ~clk_in;
  grtc_global_control u_grtc_global_control (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reset_pin_n_in(rst_n), .trigger_pin_n_in(trig_n),
    .sync_in(sync_in), .sync_out(sync_out), .ctrl_out(ctrl),
    .video_standard_select_out(std));
  grtc_pin_model u_grtc_pin_model (.clk_in(clk_in), .rst_req_in(rst_req),
    .trig_req_in(trig_req), .reset_pin_n_out(rst_n), .trigger_pin_n_out(trig_n));
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Run is short; a hang past this many cycles is a fault
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Six cycles cover sync stages, edge detect and output register
  task automatic pins(input logic r, input logic t);
    @(posedge clk_in);
    rst_req <= r;
    trig_req <= t;
    repeat (6) @(posedge clk_in);
    #1;
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1 chk("ctrl_rst", {1'b0, ctrl}, 8'h50);
    chk("std_rst", {6'h0, std}, 8'h00);
    rd_reg(8'h00);
    chk("reg_rst", d, GLOBAL_CONTROL_RST);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      wr_reg(8'h00, {2'b10, ROWS[i][9:7], 1'b0, i[1:0]});
      pins(1'b0, 1'b1);
      chk("ctrl_act", {1'b0, ctrl}, {1'b0, ROWS[i][6:0]});
      chk("std", {6'h0, std}, {6'h0, i[1:0]});
      pins(1'b0, 1'b0);
      chk("ctrl_idle", {1'b0, ctrl}, 8'h00);
    end
    rd_reg(8'h00);
    chk("readback", d, 8'ha9);
    rd_reg(8'h01);
    chk("unmapped", d, 8'h00);
    $display("action table done");
    wr_reg(8'h00, 8'hb0);
    grabs = 0;
    @(posedge clk_in);
    trig_req <= 1'b1;
    repeat (8) begin
      @(posedge clk_in);
      #1 grabs += (ctrl.grab_strobe === 1'b1);
    end
    pins(1'b0, 1'b0);
    chk("grab_count", 8'(grabs), 8'h01);
    wr_reg(8'h00, 8'hb8);
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    chk("toggle_on", {1'b0, ctrl}, 8'h12);
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    chk("toggle_off", {1'b0, ctrl}, 8'h00);
    $display("grab and toggle done");
    @(posedge clk_in);
    sync_in <= 2'h3;
    wr_reg(8'h00, 8'h80);
    pins(1'b0, 1'b0);
    chk("sync_on", {6'h0, sync_out}, 8'h03);
    wr_reg(8'h00, 8'h84);
    pins(1'b0, 1'b0);
    chk("sync_off", {6'h0, sync_out}, 8'h00);
    wr_reg(8'h00, 8'h00);
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
    chk("manual_hold", {1'b0, ctrl}, 8'h50);
    wr_reg(8'h00, 8'h80);
    pins(1'b0, 1'b0);
    chk("manual_run", {1'b0, ctrl}, 8'h00);
    $display("sync and manual done");
    wr_reg(8'h00, 8'h40);
    pins(1'b0, 1'b0);
    chk("auto_run", {1'b0, ctrl}, 8'h00);
    pins(1'b1, 1'b0);
    chk("auto_hold", {1'b0, ctrl}, 8'h50);
    rd_reg(8'h00);
    chk("auto_runbit", {7'h0, d[7]}, 8'h00);
    wr_reg(8'h00, 8'hc0);
    pins(1'b1, 1'b0);
    chk("auto_ignore", {1'b0, ctrl}, 8'h50);
    pins(1'b0, 1'b0);
    chk("auto_restart", {1'b0, ctrl}, 8'h00);
    $display("auto restart done");
    wr_reg(8'h00, 8'hb8);
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    chk("toggle_pre", {1'b0, ctrl}, 8'h12);
    wr_reg(8'h00, 8'h38);
    wr_reg(8'h00, 8'hbb);
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    chk("toggle_soft", {1'b0, ctrl}, 8'h12);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1 chk("mid_rst", {1'b0, ctrl}, 8'h50);
    chk("mid_std", {6'h0, std}, 8'h00);
    rd_reg(8'h00);
    chk("mid_reg", d, GLOBAL_CONTROL_RST);
    wr_reg(8'h00, 8'hb8);
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    chk("toggle_hard", {1'b0, ctrl}, 8'h12);
    $display("reset toggle done");
    results();
  end
endmodule
